//--- logic/vpi_unit.sv
// Vectored priority interrupt unit with an AXI4-Lite register port.
// Assumes same-clock pulses from timers, display, serial, I2C and the core.
// Operation
// RULE1 - Fourteen sources: four pins, eight internal, software break, reset.
// RULE2 - Accepting an interrupt saves program counter and status onto the stack.
// RULE3 - Acceptance sets the disable flag and clears the accepted request bit.
// RULE4 - After saving, the program counter loads from the source vector.
// RULE5 - Maskable source taken only if enabled, requested and flag clear.
// RULE6 - Software may clear request bits but never set them.
// RULE7 - Each maskable source has request and enable; enables freely writable.
// RULE8 - Reset is non-maskable with highest priority.
// RULE9 - Software break has no enable, ignores flag, lowest priority.
// RULE10 - Polarity bits 3 to 5 pick pin edge, zero rising, reset zero.
// RULE11 - Fixed priority order and vector addresses from FFFE down to FFDE.
// RULE12 - Periodic request every 4096 oscillator periods while select bit is zero.
// RULE13 - Each timer raises its own request on overflow.
// RULE14 - Display block done raises a request after a character block.
// RULE15 - Vertical sync raises a request on a selectable edge.
// RULE16 - Serial unit and I2C interface raise separate requests.
// RULE17 - Patch enable register resets to zero; low bits enable two slots.
// RULE18 - Timer request comes on the count pulse after reaching zero.
// RULE19 - Serial request set after the transfer clock counts eight times.
// RULE20 - Highest pending eligible source served first, others stay pending.
// RULE21 - Acceptance sampled only at instruction boundaries.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module vpi_unit (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite slave
  input  wire logic [vpi_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [vpi_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // External pins
  input  wire logic                       external_irq_one,
  input  wire logic                       external_irq_two,
  input  wire logic                       external_irq_three,
  input  wire logic                       vsync_in,
  // Internal sources
  input  wire logic                       display_block_done,
  input  wire logic [3:0]                 timer_count_pulse,
  input  wire logic [3:0]                 timer_at_zero,
  input  wire logic                       serial_start,
  input  wire logic                       serial_clk_pulse,
  input  wire logic                       i2c_event,
  // Core side
  input  wire logic                       cpu_boundary,
  input  wire logic                       software_break,
  input  wire logic                       cpu_iflag_wr,
  input  wire logic                       cpu_iflag_val,
  output vpi_pkg::vpi_take_t              cpu_take,
  output logic                            iflag,
  output logic                            patch_slot_one_enable,
  output logic                            patch_slot_two_enable
);

  // Register select codes
  localparam logic [2:0] SEL_REQ   = 3'h0;
  localparam logic [2:0] SEL_ENA   = 3'h1;
  localparam logic [2:0] SEL_POL   = 3'h2;
  localparam logic [2:0] SEL_PWM1  = 3'h3;
  localparam logic [2:0] SEL_PATCH = 3'h4;
  localparam logic [2:0] SEL_STAT  = 3'h5;
  localparam logic [2:0] SEL_NONE  = 3'h7;
  logic [11:0]         req_r, req_nxt, ena_r, tick_cnt_r, events, sw_clear, hw_clear;
  logic [7:0]          pol_r, pwm1_r, rom_patch_enable_r, aw_addr_r;
  logic [3:0]          ser_cnt_r, last_src_r, pin_edges, pin_bus, pol_bus, win_idx, w_strb_r;
  logic [31:0]         w_data_r, wmask, rdata_r;
  logic [1:0]          bresp_r, rresp_r;
  logic                iflag_r, reset_pend_r, swb_pend_r, any_mask, accept, do_write, take_reset;
  logic                take_mask, take_swb, aw_full_r, w_full_r, bvalid_r, rvalid_r;
  vpi_pkg::vpi_state_t state_r;
  vpi_pkg::vpi_take_t  take_r;

  // Byte offset to register select
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      vpi_pkg::ADDR_REQ:   reg_sel = SEL_REQ;
      vpi_pkg::ADDR_ENA:   reg_sel = SEL_ENA;
      vpi_pkg::ADDR_POL:   reg_sel = SEL_POL;
      vpi_pkg::ADDR_PWM1:  reg_sel = SEL_PWM1;
      vpi_pkg::ADDR_PATCH: reg_sel = SEL_PATCH;
      vpi_pkg::ADDR_STAT:  reg_sel = SEL_STAT;
      default:             reg_sel = SEL_NONE;
    endcase
  endfunction

  // Vector of a maskable request index
  function automatic logic [15:0] req_vector(input logic [3:0] idx);
    case (idx)
      4'h0:    req_vector = vpi_pkg::VEC_DISP;
      4'h1:    req_vector = vpi_pkg::VEC_EXT2;
      4'h2:    req_vector = vpi_pkg::VEC_EXT1;
      4'h3:    req_vector = vpi_pkg::VEC_TMR4;
      4'h4:    req_vector = vpi_pkg::VEC_TICK;
      4'h5:    req_vector = vpi_pkg::VEC_VSYNC;
      4'h6:    req_vector = vpi_pkg::VEC_TMR3;
      4'h7:    req_vector = vpi_pkg::VEC_TMR2;
      4'h8:    req_vector = vpi_pkg::VEC_TMR1;
      4'h9:    req_vector = vpi_pkg::VEC_SER;
      4'ha:    req_vector = vpi_pkg::VEC_I2C;
      default: req_vector = vpi_pkg::VEC_EXT3;
    endcase
  endfunction

  // Pin edge detectors, ext one/two/three and vsync
  assign pin_bus = {vsync_in, external_irq_three, external_irq_two, external_irq_one};
  assign pol_bus = {pol_r[vpi_pkg::POL_VSYNC_BIT], pol_r[vpi_pkg::POL_EXT3_BIT],
                    pol_r[vpi_pkg::POL_EXT2_BIT], pol_r[vpi_pkg::POL_EXT1_BIT]}; // RULE10 RULE15
  for (genvar g = 0; g < 4; g++) begin : g_pin
    vpi_edge_det u_edge (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin        (pin_bus[g]),
      .pol        (pol_bus[g]),
      .edge_pulse (pin_edges[g])
    );
  end

  // Periodic tick divider, runs only while select bit is zero
  always_ff @(posedge aclk) begin
    if (!aresetn || pwm1_r[vpi_pkg::TICK_SEL_BIT]) begin
      tick_cnt_r <= 12'h000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 12'h001; // RULE12
    end
  end

  // Serial transfer clock counter, stops at eight
  always_ff @(posedge aclk) begin
    if (!aresetn || serial_start) begin
      ser_cnt_r <= 4'h0;
    end else if (serial_clk_pulse && ser_cnt_r != 4'(vpi_pkg::SER_BITS)) begin
      ser_cnt_r <= ser_cnt_r + 4'h1; // RULE19
    end
  end

  // Source events gathered in priority order
  always_comb begin
    events                      = '0; // RULE1
    events[vpi_pkg::REQ_DISP]   = display_block_done; // RULE14
    events[vpi_pkg::REQ_EXT2]   = pin_edges[1];
    events[vpi_pkg::REQ_EXT1]   = pin_edges[0];
    events[vpi_pkg::REQ_EXT3]   = pin_edges[2];
    events[vpi_pkg::REQ_VSYNC]  = pin_edges[3]; // RULE15
    events[vpi_pkg::REQ_TMR1]   = timer_count_pulse[0] & timer_at_zero[0]; // RULE13 RULE18
    events[vpi_pkg::REQ_TMR2]   = timer_count_pulse[1] & timer_at_zero[1]; // RULE13 RULE18
    events[vpi_pkg::REQ_TMR3]   = timer_count_pulse[2] & timer_at_zero[2]; // RULE13 RULE18
    events[vpi_pkg::REQ_TMR4]   = timer_count_pulse[3] & timer_at_zero[3]; // RULE13 RULE18
    events[vpi_pkg::REQ_TICK]   = ~pwm1_r[vpi_pkg::TICK_SEL_BIT]
                                  & (tick_cnt_r == 12'(vpi_pkg::TICK_CYCLES - 1)); // RULE12
    events[vpi_pkg::REQ_SER]    = serial_clk_pulse & ~serial_start
                                  & (ser_cnt_r == 4'(vpi_pkg::SER_BITS - 1)); // RULE19 RULE16
    events[vpi_pkg::REQ_I2C]    = i2c_event; // RULE16
  end

  // Winner among enabled pending requests
  vpi_prio_enc u_prio (
    .eligible (req_r & ena_r), // RULE5 RULE20
    .any      (any_mask),
    .index    (win_idx)
  );

  // Acceptance at instruction boundaries only
  assign accept     = (state_r == vpi_pkg::ST_IDLE) && cpu_boundary; // RULE21
  assign take_reset = accept && reset_pend_r; // RULE8
  assign take_mask  = accept && !reset_pend_r && any_mask && !iflag_r; // RULE5 RULE11
  assign take_swb   = accept && !reset_pend_r && !take_mask && swb_pend_r; // RULE9

  // Write clears from software, accept clear from hardware
  assign wmask    = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign sw_clear = (do_write && reg_sel(aw_addr_r) == SEL_REQ)
                    ? (~w_data_r[11:0] & wmask[11:0]) : 12'h000; // RULE6
  assign hw_clear = take_mask ? (12'h001 << win_idx) : 12'h000; // RULE3 RULE20

  // Request bits, a new event wins over any clear
  assign req_nxt = (req_r & ~sw_clear & ~hw_clear) | events; // RULE6 RULE7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= vpi_pkg::REQ_RST;
    end else begin
      req_r <= req_nxt;
    end
  end

  // Reset pending from release, break pending from the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pend_r <= 1'b1; // RULE8
      swb_pend_r   <= 1'b0;
    end else begin
      if (take_reset) begin
        reset_pend_r <= 1'b0;
      end
      if (software_break) begin
        swb_pend_r <= 1'b1; // RULE9
      end else if (take_swb) begin
        swb_pend_r <= 1'b0;
      end
    end
  end

  // Disable flag, acceptance wins over a core update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iflag_r <= 1'b1;
    end else if (take_reset || take_mask || take_swb) begin
      iflag_r <= 1'b1; // RULE3
    end else if (cpu_iflag_wr) begin
      iflag_r <= cpu_iflag_val;
    end
  end

  // Take sequence: save state, then load vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= vpi_pkg::ST_IDLE;
      take_r     <= '0;
      last_src_r <= vpi_pkg::SRC_NONE;
    end else begin
      case (state_r)
        vpi_pkg::ST_IDLE: begin
          take_r.load_vector <= 1'b0;
          if (take_reset || take_mask || take_swb) begin
            state_r           <= vpi_pkg::ST_SAVE;
            take_r.save_state <= 1'b1; // RULE2
            if (take_reset) begin
              take_r.source      <= vpi_pkg::SRC_RESET;
              take_r.vector_addr <= vpi_pkg::VEC_RESET; // RULE11
            end else if (take_mask) begin
              take_r.source      <= win_idx + 4'h2;
              take_r.vector_addr <= req_vector(win_idx); // RULE11
            end else begin
              take_r.source      <= vpi_pkg::SRC_SWB;
              take_r.vector_addr <= vpi_pkg::VEC_SWB; // RULE9
            end
          end
        end
        vpi_pkg::ST_SAVE: begin
          state_r            <= vpi_pkg::ST_LOAD;
          take_r.save_state  <= 1'b0;
          take_r.load_vector <= 1'b1; // RULE4
        end
        vpi_pkg::ST_LOAD: begin
          state_r            <= vpi_pkg::ST_IDLE;
          take_r.load_vector <= 1'b0;
          last_src_r         <= take_r.source;
        end
        default: begin
          state_r <= vpi_pkg::ST_IDLE;
          take_r  <= '0;
        end
      endcase
    end
  end

  // Write address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Writable control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena_r              <= vpi_pkg::ENA_RST;
      pol_r              <= vpi_pkg::POL_RST; // RULE10
      pwm1_r             <= vpi_pkg::PWM1_RST;
      rom_patch_enable_r <= vpi_pkg::PATCH_RST; // RULE17
    end else if (do_write) begin
      case (reg_sel(aw_addr_r))
        SEL_ENA:   ena_r <= (ena_r & ~wmask[11:0]) | (w_data_r[11:0] & wmask[11:0]); // RULE7
        SEL_POL:   if (w_strb_r[0]) pol_r <= w_data_r[7:0];
        SEL_PWM1:  if (w_strb_r[0]) pwm1_r <= w_data_r[7:0]; // RULE12
        SEL_PATCH: if (w_strb_r[0]) rom_patch_enable_r <= w_data_r[7:0];
        default:   ;
      endcase
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= vpi_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (reg_sel(aw_addr_r) == SEL_NONE) ? vpi_pkg::RESP_SLVERR
                                                   : vpi_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data, captured at address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= vpi_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= vpi_pkg::RESP_OKAY;
      case (reg_sel({s_axi_araddr[7:2], 2'b00}))
        SEL_REQ:   rdata_r <= {20'h00000, req_r};
        SEL_ENA:   rdata_r <= {20'h00000, ena_r};
        SEL_POL:   rdata_r <= {24'h000000, pol_r};
        SEL_PWM1:  rdata_r <= {24'h000000, pwm1_r};
        SEL_PATCH: rdata_r <= {24'h000000, rom_patch_enable_r};
        SEL_STAT:  rdata_r <= {24'h000000, reset_pend_r, swb_pend_r, (state_r != vpi_pkg::ST_IDLE),
                               last_src_r, iflag_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= vpi_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Bus handshakes and outputs
  assign s_axi_awready         = !aw_full_r && !bvalid_r;
  assign s_axi_wready          = !w_full_r && !bvalid_r;
  assign s_axi_bvalid          = bvalid_r;
  assign s_axi_bresp           = bresp_r;
  assign s_axi_arready         = !rvalid_r;
  assign s_axi_rvalid          = rvalid_r;
  assign s_axi_rdata           = rdata_r;
  assign s_axi_rresp           = rresp_r;
  assign cpu_take              = take_r;
  assign iflag                 = iflag_r;
  assign patch_slot_one_enable = rom_patch_enable_r[vpi_pkg::PATCH1_BIT]; // RULE17
  assign patch_slot_two_enable = rom_patch_enable_r[vpi_pkg::PATCH2_BIT]; // RULE17

endmodule // vpi_unit

//--- logic/vpi_pkg.sv
// Package for the vectored priority interrupt unit.
// Assumes one 20 MHz core clock that also stands for the main oscillator.
package vpi_pkg;

  // Source counts
  localparam int NUM_SOURCES = 14;
  localparam int NUM_REQ     = 12;

  // Request and enable bit positions, index 0 is highest maskable priority
  localparam int REQ_DISP  = 0;
  localparam int REQ_EXT2  = 1;
  localparam int REQ_EXT1  = 2;
  localparam int REQ_TMR4  = 3;
  localparam int REQ_TICK  = 4;
  localparam int REQ_VSYNC = 5;
  localparam int REQ_TMR3  = 6;
  localparam int REQ_TMR2  = 7;
  localparam int REQ_TMR1  = 8;
  localparam int REQ_SER   = 9;
  localparam int REQ_I2C   = 10;
  localparam int REQ_EXT3  = 11;

  // Source numbers, equal to the fixed priority
  localparam logic [3:0] SRC_RESET = 4'h1;
  localparam logic [3:0] SRC_SWB   = 4'he;
  localparam logic [3:0] SRC_NONE  = 4'h0;

  // Low byte address of each vector pair
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_DISP  = 16'hfffc;
  localparam logic [15:0] VEC_EXT2  = 16'hfffa;
  localparam logic [15:0] VEC_EXT1  = 16'hfff8;
  localparam logic [15:0] VEC_TMR4  = 16'hfff4;
  localparam logic [15:0] VEC_TICK  = 16'hfff2;
  localparam logic [15:0] VEC_VSYNC = 16'hfff0;
  localparam logic [15:0] VEC_TMR3  = 16'hffee;
  localparam logic [15:0] VEC_TMR2  = 16'hffec;
  localparam logic [15:0] VEC_TMR1  = 16'hffea;
  localparam logic [15:0] VEC_SER   = 16'hffe8;
  localparam logic [15:0] VEC_I2C   = 16'hffe6;
  localparam logic [15:0] VEC_EXT3  = 16'hffe4;
  localparam logic [15:0] VEC_SWB   = 16'hffde;

  // Register byte offsets
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] ADDR_REQ   = 8'h00;
  localparam logic [7:0] ADDR_ENA   = 8'h04;
  localparam logic [7:0] ADDR_POL   = 8'h08;
  localparam logic [7:0] ADDR_PWM1  = 8'h0c;
  localparam logic [7:0] ADDR_PATCH = 8'h10;
  localparam logic [7:0] ADDR_STAT  = 8'h14;

  // Reset values
  localparam logic [11:0] REQ_RST   = 12'h000;
  localparam logic [11:0] ENA_RST   = 12'h000;
  localparam logic [7:0]  POL_RST   = 8'h00;
  localparam logic [7:0]  PWM1_RST  = 8'h00;
  localparam logic [7:0]  PATCH_RST = 8'h00;

  // Field positions
  localparam int POL_EXT1_BIT  = 3;
  localparam int POL_EXT2_BIT  = 4;
  localparam int POL_EXT3_BIT  = 5;
  localparam int POL_VSYNC_BIT = 6;
  localparam int TICK_SEL_BIT  = 0;
  localparam int PATCH1_BIT    = 0;
  localparam int PATCH2_BIT    = 1;

  // Timing counts
  localparam int TICK_OSC_PERIODS = 4096;
  localparam int OSC_PER_ACLK     = 1;
  localparam int TICK_CYCLES      = TICK_OSC_PERIODS / OSC_PER_ACLK;
  localparam int SER_BITS         = 8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Take sequence states
  typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_LOAD} vpi_state_t;

  // Indication to the core
  typedef struct packed {
    logic        save_state;
    logic        load_vector;
    logic [15:0] vector_addr;
    logic [3:0]  source;
  } vpi_take_t;

endpackage

//--- logic/vpi_edge_det.sv
// Pin synchroniser and selectable edge detector.
// Assumes an asynchronous pin; pol low picks rising, high picks falling.
`timescale 1ns/1ps
module vpi_edge_det (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  input  wire logic pol,
  output logic      edge_pulse
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Two-stage synchroniser and history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Active edge by polarity
  assign edge_pulse = pol ? (prev_r & ~sync2_r) : (~prev_r & sync2_r);
endmodule // vpi_edge_det

//--- logic/vpi_prio_enc.sv
// Fixed priority encoder, bit 0 wins.
// Assumes eligible bits are already masked.
`timescale 1ns/1ps
module vpi_prio_enc (
  input  wire logic [11:0] eligible,
  output logic             any,
  output logic [3:0]       index
);
  // Scan from lowest priority up so the highest ends on top
  always_comb begin
    any   = 1'b0;
    index = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (eligible[i]) begin
        any   = 1'b1;
        index = 4'(i);
      end
    end
  end
endmodule // vpi_prio_enc

//--- tb/vpi_unit_assertions.sv
// Port checker for the interrupt unit, bound onto vpi_unit.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module vpi_unit_assertions (
  input logic               aclk,
  input logic               aresetn,
  input logic               s_axi_arvalid,
  input logic               s_axi_arready,
  input logic               s_axi_rvalid,
  input logic               s_axi_rready,
  input logic               s_axi_bvalid,
  input logic               s_axi_bready,
  input logic               cpu_boundary,
  input vpi_pkg::vpi_take_t cpu_take,
  input logic               iflag,
  input logic               patch_slot_one_enable,
  input logic               patch_slot_two_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Vector low byte for a source number, gap below priority 4
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    if (s == 4'he) return 16'hffde;
    return (s < 4'h5) ? 16'h0 - {s, 1'b0} : 16'hfffe - {s, 1'b0};
  endfunction
  a_save_then_load: assert property (cpu_take.save_state |=> cpu_take.load_vector
    && !cpu_take.save_state) else $error("load did not follow save");
  a_take_sets_flag: assert property (cpu_take.save_state |-> iflag)
    else $error("flag clear after take");
  a_flag_blocks: assert property (cpu_take.save_state && cpu_take.source != 4'h1
    && cpu_take.source != 4'he |-> $past(iflag) == 1'b0) else $error("take with flag set");
  a_take_boundary: assert property (cpu_take.save_state |-> $past(cpu_boundary))
    else $error("take off boundary");
  a_vector_map: assert property (cpu_take.save_state
    |-> cpu_take.vector_addr == vec_of(cpu_take.source)) else $error("wrong vector");
  a_vector_holds: assert property (cpu_take.load_vector |-> $stable(cpu_take.vector_addr))
    else $error("vector moved");
  a_reset_values: assert property ($rose(aresetn) |-> iflag && !patch_slot_one_enable
    && !patch_slot_two_enable) else $error("bad reset state");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
endmodule // vpi_unit_assertions
bind vpi_unit vpi_unit_assertions u_vpi_unit_assertions (.*);

//--- tb/vpi_core_model.sv
// Core model: instruction boundaries and disable flag writes.
// Assumes the unit's clock and reset.
`timescale 1ns/1ps
module vpi_core_model (
  input  logic aclk,
  input  logic aresetn,
  input  logic clear_flag,
  input  logic slow,
  output logic cpu_boundary,
  output logic cpu_iflag_wr,
  output logic cpu_iflag_val
);
  logic [1:0] cnt_r;
  // Boundary each cycle, or one in four when slow
  always_ff @(posedge aclk) begin
    cnt_r <= aresetn ? cnt_r + 2'h1 : 2'h0;
    cpu_iflag_wr <= aresetn && clear_flag;
  end
  assign cpu_boundary = aresetn && (!slow || cnt_r == 2'h0);
  assign cpu_iflag_val = 1'b0;
endmodule // vpi_core_model

//--- tb/testbench.sv
// Bench for vpi_unit: bus tasks, event pulses, take checks.
// Assumes vpi_pkg and the core model.
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0, display_block_done = 1'b0, serial_start = 1'b0;
  logic serial_clk_pulse = 1'b0, i2c_event = 1'b0, software_break = 1'b0;
  logic clear_flag = 1'b0, slow = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, cpu_boundary, cpu_iflag_wr, cpu_iflag_val, iflag;
  logic patch_slot_one_enable, patch_slot_two_enable, s_axi_bready, s_axi_rready;
  logic [3:0] pins = 4'h0, timer_count_pulse = 4'h0, timer_at_zero = 4'h0, s_axi_wstrb;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic external_irq_one, external_irq_two, external_irq_three, vsync_in;
  vpi_pkg::vpi_take_t cpu_take;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  assign {vsync_in, external_irq_three, external_irq_two, external_irq_one} = pins;
  assign s_axi_bready = 1'b1;
  assign s_axi_rready = 1'b1;
  assign s_axi_wstrb = 4'hf;
  vpi_unit u_vpi_unit (.*);
  vpi_core_model u_vpi_core_model (.*);
  // Clock and hang guard
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      if (hb) chk("bresp", {30'h0, a > 8'h14, 1'b0}, 32'(s_axi_bresp));
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    logic ha, hr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      if (hr) chk($sformatf("reg %h", a), e, s_axi_rdata);
      if (hr) chk("rresp", 32'(re), 32'(s_axi_rresp));
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
  endtask
  task automatic take(input logic [3:0] s, input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (cpu_take.save_state !== 1'b1 && n < 60);
    chk("source", 32'(s), 32'(cpu_take.source));
    chk("vector", 32'(v), 32'(cpu_take.vector_addr));
    chk("iflag", 32'h1, 32'(iflag));
    @(posedge aclk);
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    take(4'h1, 16'hfffe);
    for (int i = 0; i < 5; i++) rc(8'(4 * i), 32'h0, 2'b00);
    rc(8'h18, 32'h0, 2'b10);
    wr(8'h18, 32'h0);
    wr(8'h0c, 32'h1);
    wr(8'h10, 32'h3);
    chk("patch", 32'h3, 32'({patch_slot_two_enable, patch_slot_one_enable}));
    display_block_done <= 1'b1;
    i2c_event <= 1'b1;
    @(posedge aclk);
    display_block_done <= 1'b0;
    i2c_event <= 1'b0;
    wr(8'h00, 32'hfff);
    rc(8'h00, 32'h401, 2'b00);
    wr(8'h04, 32'hfff);
    rc(8'h04, 32'hfff, 2'b00);
    clear_flag <= 1'b1;
    @(posedge aclk);
    clear_flag <= 1'b0;
    take(4'h2, 16'hfffc);
    rc(8'h00, 32'h400, 2'b00);
    clear_flag <= 1'b1;
    @(posedge aclk);
    clear_flag <= 1'b0;
    take(4'hc, 16'hffe6);
    pins <= 4'hf;
    repeat (5) @(posedge aclk);
    rc(8'h00, 32'h826, 2'b00);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h78);
    pins <= 4'h0;
    repeat (5) @(posedge aclk);
    rc(8'h00, 32'h826, 2'b00);
    wr(8'h00, 32'h0);
    timer_at_zero <= 4'hf;
    @(posedge aclk);
    timer_at_zero <= 4'h0;
    timer_count_pulse <= 4'hf;
    @(posedge aclk);
    timer_at_zero <= 4'hf;
    @(posedge aclk);
    timer_at_zero <= 4'h0;
    timer_count_pulse <= 4'h0;
    serial_start <= 1'b1;
    @(posedge aclk);
    serial_start <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i == 7) rc(8'h00, 32'h1c8, 2'b00);
      serial_clk_pulse <= 1'b1;
      @(posedge aclk);
      serial_clk_pulse <= 1'b0;
      @(posedge aclk);
    end
    rc(8'h00, 32'h3c8, 2'b00);
    slow <= 1'b1;
    software_break <= 1'b1;
    @(posedge aclk);
    software_break <= 1'b0;
    take(4'he, 16'hffde);
    wr(8'h00, 32'h0);
    rc(8'h14, 32'h1d, 2'b00);
    wr(8'h0c, 32'h0);
    repeat (4080) @(posedge aclk);
    rc(8'h00, 32'h0, 2'b00);
    repeat (20) @(posedge aclk);
    rc(8'h00, 32'h010, 2'b00);
    final_report();
  end
endmodule // testbench
